/* File: hmis_pkg.sv */
package hmis_pkg;

  // ==========================================================
  // Record layout (byte index within a stored message record)
  // ==========================================================
  localparam logic [7:0] REC_SRC_IDX = 8'h00;
  localparam logic [7:0] REC_FUNC_IDX = 8'h01;
  localparam logic [7:0] REC_SUBF_IDX = 8'h02;
  localparam logic [7:0] REC_DIR_IDX = 8'h03;
  localparam logic [7:0] REC_LEN_IDX = 8'h04;
  localparam logic [7:0] REC_HDR_BYTES = 8'h05;

  // ==========================================================
  // Legal field ranges
  // ==========================================================
  localparam logic [7:0] SRC_ADDR_MAX = 8'h1f;
  localparam logic [7:0] SRC_BROADCAST = 8'hff;
  localparam logic [7:0] FUNC_CODE_MAX = 8'h6f;
  localparam logic [7:0] DATA_LEN_MAX = 8'h86;
  localparam logic [6:0] UNIT_INDEX_LIMIT = 7'h40;

  // ==========================================================
  // Event table positions and reset values
  // ==========================================================
  localparam int EVT_ENTRIES = 7;
  localparam int EVT_SUMMARY = 0;
  localparam int EVT_MEM_DGRAM = 1;
  localparam int EVT_MODULE_STAT = 2;
  localparam int EVT_DEVICE_STAT = 3;
  localparam int EVT_OUTPUTS_SENT = 4;
  localparam int EVT_CMD_DONE = 5;
  localparam int EVT_DGRAM = 6;
  localparam logic [6:0] EVT_TABLE_RST = 7'h00;
  localparam logic [6:0] MASK_TABLE_RST = 7'h7f;

  // ==========================================================
  // Message store slots
  // ==========================================================
  localparam logic [1:0] SLOT_MEM = 2'h0;
  localparam logic [1:0] SLOT_NONMEM = 2'h1;
  localparam logic [1:0] SLOT_REPLY = 2'h2;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam longint CLK_HZ = 250000000;
  localparam longint REPLY_TIMEOUT_S = 10;
  localparam longint REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_S * CLK_HZ;

  // ==========================================================
  // Host operations and answers
  // ==========================================================
  typedef enum logic [1:0] {
    HMIS_OP_READ_RECEIVED_MESSAGE = 2'h0,
    HMIS_OP_READ_EVENT_TABLE = 2'h1,
    HMIS_OP_WRITE_INTERRUPT_MASK_TABLE = 2'h2,
    HMIS_OP_NONE = 2'h3
  } hmis_op_t;

  typedef enum logic [2:0] {
    HMIS_ST_SUCCESS = 3'h0,
    HMIS_ST_UNIT_INDEX_OUT_OF_RANGE = 3'h1,
    HMIS_ST_NOT_INITIALIZED = 3'h2,
    HMIS_ST_MODULE_FAILED = 3'h3,
    HMIS_ST_MODULE_ENGAGED = 3'h4,
    HMIS_ST_NO_MESSAGE_AVAILABLE = 3'h5,
    HMIS_ST_TRANSMISSION_FAILED = 3'h6,
    HMIS_ST_FIRMWARE_FAULT = 3'h7
  } hmis_status_t;

endpackage

/* File: hmis_mem_if.sv */
`timescale 1ns/1ps
// Port pair between the service logic and the message store
interface hmis_mem_if #(
  parameter int AW = 10
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
    output rd_data);
endinterface

/* File: hmis_msg_store.sv */
`timescale 1ns/1ps
// Byte store for three message records; read data registered
module hmis_msg_store #(
  parameter int AW = 10
) (
  input wire logic sys_clk,
  hmis_mem_if.mem port
);
  logic [7:0] mem_r [0:(1<<AW)-1];
  logic [7:0] rd_data_r;

  // ==========================================================
  // Storage; no reset, contents are only read behind a pending flag
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
    if (port.rd_en) begin
      rd_data_r <= mem_r[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_r;
endmodule

/* File: hmis_service.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Record opens: source, function, subfunction codes
// (R2) Then directed flag, length, that many bytes
// (R3) Outstanding reply: deliver only on success
// (R4) Otherwise memory message delivered first
// (R5) Non-memory message only when no memory one
// (R6) Nothing pending: fail with no message
// (R7) Exchange running hides unsolicited datagrams
// (R8) Failures carry one of seven status codes
// (R9) Host picks module by unit index
// (R10) Seven event entries, entry 0 summary
// (R11) Entry reads 1 once its event occurred
// (R12) Events recorded even when interrupt masked
// (R13) Reading event table clears all entries
// (R14) Mask table: 0 enables, 1 disables
// (R15) One write applies all seven mask bits
// (R16) Reply exchange errors after ten seconds
// (R17) Interrupt when unmasked entry set; summary
module hmis_service
  import hmis_pkg::*;
#(
  parameter logic [31:0] REPLY_TIMEOUT = 32'(REPLY_TIMEOUT_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [6:0] req_unit_index,
  input wire logic [6:0] req_mask_table,
  output logic ans_done,
  output logic [2:0] ans_status,
  output logic [6:0] ans_event_table,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_byte,
  output logic out_last,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [1:0] rx_kind,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic xchg_start,
  input wire logic xchg_tx_fail,
  input wire logic module_initialized,
  input wire logic module_failed,
  input wire logic firmware_fault,
  input wire logic ev_module_status,
  input wire logic ev_device_status,
  input wire logic ev_outputs_sent,
  input wire logic ev_command_done,
  output logic xchg_busy,
  output logic [6:0] mask_table,
  output logic irq
);
  typedef enum {S_IDLE, S_FETCH, S_HOLD} hmis_rd_state_t;
  typedef enum {X_IDLE, X_RUN, X_DONE, X_ERR} hmis_xchg_state_t;

  hmis_mem_if #(.AW(10)) mport ();
  hmis_msg_store #(.AW(10)) u_store (.sys_clk(sys_clk), .port(mport));

  hmis_rd_state_t st_r;
  hmis_xchg_state_t xs_r;
  logic [2:0] pend_r;
  logic [7:0] wr_idx_r, len_r, rd_idx_r, last_idx_r;
  logic hdr_bad_r;
  logic [1:0] rd_slot_r;
  logic [31:0] tmo_r;
  logic [6:0] evt_r, mask_r, evt_q_r;
  logic done_r;
  logic [2:0] status_r;

  // ==========================================================
  // Capture of incoming records
  // ==========================================================
  wire logic rx_slot_free = !pend_r[rx_kind];
  wire logic rx_kind_ok = (rx_kind == SLOT_REPLY) ? (xs_r == X_RUN) : (rx_kind != 2'h3);
  assign rx_ready = rx_slot_free && rx_kind_ok;
  wire logic rx_take = rx_valid && rx_ready;
  wire logic src_bad = (rx_byte > SRC_ADDR_MAX) && (rx_byte != SRC_BROADCAST);
  // Each header byte except the subfunction code is range-checked as it passes
  wire logic byte_bad = ((wr_idx_r == REC_SRC_IDX) && src_bad) ||           // R1
                        ((wr_idx_r == REC_FUNC_IDX) && (rx_byte > FUNC_CODE_MAX)) || // R1
                        ((wr_idx_r == REC_DIR_IDX) && (rx_byte > 8'h01)) || // R2
                        ((wr_idx_r == REC_LEN_IDX) && (rx_byte > DATA_LEN_MAX)); // R2
  wire logic [7:0] cur_len = (wr_idx_r == REC_LEN_IDX) ? rx_byte : len_r;
  // A record must end exactly after its declared data count
  wire logic end_ok = (wr_idx_r >= REC_LEN_IDX) && (wr_idx_r == REC_LEN_IDX + cur_len); // R2
  wire logic rec_good = rx_take && rx_last && !hdr_bad_r && !byte_bad && end_ok;
  wire logic [2:0] pend_set = rec_good ? (3'h1 << rx_kind) : 3'h0;

  assign mport.wr_en = rx_take;
  assign mport.wr_addr = {rx_kind, wr_idx_r};
  assign mport.wr_data = rx_byte;

  always_ff @(posedge sys_clk) begin
    if (rst || (rx_take && rx_last)) begin
      wr_idx_r <= 8'h00;
      hdr_bad_r <= 1'b0;
      len_r <= 8'h00;
    end else if (rx_take) begin
      wr_idx_r <= wr_idx_r + 8'h01;
      hdr_bad_r <= hdr_bad_r || byte_bad || (wr_idx_r == 8'hff);
      len_r <= cur_len;
    end
  end

  // ==========================================================
  // Reply exchange tracking and timeout
  // ==========================================================
  wire logic tmo_hit = (tmo_r >= REPLY_TIMEOUT - 32'h1);
  wire logic xchg_clear;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xs_r <= X_IDLE;
      tmo_r <= 32'h0;
    end else begin
      unique case (xs_r)
        X_IDLE: begin
          tmo_r <= 32'h0;
          if (xchg_start) xs_r <= X_RUN;
        end
        X_RUN: begin
          tmo_r <= tmo_r + 32'h1;
          if (pend_set[SLOT_REPLY]) xs_r <= X_DONE;
          else if (xchg_tx_fail || tmo_hit) xs_r <= X_ERR; // R16
        end
        X_DONE, X_ERR: begin
          if (xchg_clear) xs_r <= X_IDLE;
        end
      endcase
    end
  end
  assign xchg_busy = (xs_r != X_IDLE);

  // ==========================================================
  // Host request decode
  // ==========================================================
  wire logic take_req = req_valid && req_ready;
  wire logic [2:0] pre_fail = (req_unit_index >= UNIT_INDEX_LIMIT) ? HMIS_ST_UNIT_INDEX_OUT_OF_RANGE : // R8
                              !module_initialized ? HMIS_ST_NOT_INITIALIZED :
                              module_failed ? HMIS_ST_MODULE_FAILED : HMIS_ST_SUCCESS;
  wire logic pre_ok = (pre_fail == HMIS_ST_SUCCESS);
  wire logic op_msg = take_req && pre_ok && (req_op == HMIS_OP_READ_RECEIVED_MESSAGE);
  wire logic op_evt = take_req && pre_ok && (req_op == HMIS_OP_READ_EVENT_TABLE);
  wire logic op_mask = take_req && pre_ok && (req_op == HMIS_OP_WRITE_INTERRUPT_MASK_TABLE);
  // While an exchange is open only its reply is visible; no datagram slot is examined
  wire logic xchg_open = (xs_r != X_IDLE);                                  // R7
  wire logic [2:0] msg_status = firmware_fault ? HMIS_ST_FIRMWARE_FAULT :
                                (xs_r == X_RUN) ? HMIS_ST_MODULE_ENGAGED :        // R3
                                (xs_r == X_ERR) ? HMIS_ST_TRANSMISSION_FAILED :   // R3
                                (xs_r == X_DONE) ? HMIS_ST_SUCCESS :              // R3
                                pend_r[SLOT_MEM] ? HMIS_ST_SUCCESS :              // R4
                                pend_r[SLOT_NONMEM] ? HMIS_ST_SUCCESS :           // R5
                                HMIS_ST_NO_MESSAGE_AVAILABLE;                     // R6
  wire logic [1:0] msg_slot = xchg_open ? SLOT_REPLY :
                              pend_r[SLOT_MEM] ? SLOT_MEM : SLOT_NONMEM;          // R4 R5
  wire logic msg_go = op_msg && (msg_status == HMIS_ST_SUCCESS);
  wire logic msg_fail = op_msg && (msg_status != HMIS_ST_SUCCESS);
  assign req_ready = (st_r == S_IDLE);

  // ==========================================================
  // Record streaming to the host
  // ==========================================================
  wire logic beat = (st_r == S_HOLD) && out_ready;
  wire logic [7:0] eff_last = (rd_idx_r == REC_LEN_IDX) ? (REC_LEN_IDX + mport.rd_data) : last_idx_r;
  wire logic finish = beat && (rd_idx_r == eff_last);
  wire logic [2:0] pend_clr = finish ? (3'h1 << rd_slot_r) : 3'h0;
  // Exchange closes once its failure is reported or its reply fully handed over
  assign xchg_clear = (msg_fail && (xs_r == X_ERR)) || (finish && (rd_slot_r == SLOT_REPLY));
  assign mport.rd_en = (st_r == S_FETCH);
  assign mport.rd_addr = {rd_slot_r, rd_idx_r};
  assign out_valid = (st_r == S_HOLD);
  assign out_byte = mport.rd_data;                                           // R1 R2
  assign out_last = (st_r == S_HOLD) && (rd_idx_r == eff_last);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= S_IDLE;
      rd_slot_r <= SLOT_MEM;
      rd_idx_r <= 8'h00;
      last_idx_r <= 8'hff;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          rd_idx_r <= 8'h00;
          last_idx_r <= 8'hff;
          if (msg_go) begin
            rd_slot_r <= msg_slot;
            st_r <= S_FETCH;
          end
        end
        S_FETCH: st_r <= S_HOLD;
        S_HOLD: begin
          if (finish) begin
            st_r <= S_IDLE;
          end else if (beat) begin
            last_idx_r <= eff_last;
            rd_idx_r <= rd_idx_r + 8'h01;
            st_r <= S_FETCH;
          end
        end
      endcase
    end
  end

  // Arrival wins over delivery; the two never touch one slot at once anyway
  always_ff @(posedge sys_clk) begin
    if (rst) pend_r <= 3'h0;
    else pend_r <= (pend_r & ~pend_clr) | pend_set;
  end

  // ==========================================================
  // Event table, mask table and interrupt
  // ==========================================================
  wire logic [6:0] ev_raw = {pend_set[SLOT_NONMEM], ev_command_done, ev_outputs_sent,
                             ev_device_status, ev_module_status, pend_set[SLOT_MEM], 1'b0}; // R10
  wire logic [6:0] ev_set = ev_raw | {6'h00, |ev_raw};                       // R17
  // Cleared on read, but an event landing in that cycle survives
  wire logic [6:0] evt_nxt = ((op_evt ? 7'h00 : evt_r)) | ev_set;            // R11 R12 R13
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_r <= EVT_TABLE_RST;
      mask_r <= MASK_TABLE_RST;
      evt_q_r <= EVT_TABLE_RST;
    end else begin
      evt_r <= evt_nxt;
      if (op_evt) evt_q_r <= evt_r;                                          // R13
      if (op_mask) mask_r <= req_mask_table;                                 // R14 R15
    end
  end
  assign mask_table = mask_r;
  assign irq = |(evt_r & ~mask_r);                                           // R14 R17
  assign ans_event_table = evt_q_r;

  // ==========================================================
  // Answer to the host
  // ==========================================================
  wire logic ans_now = (take_req && !op_msg) || msg_fail || finish;
  wire logic [2:0] ans_code = !pre_ok ? pre_fail : msg_fail ? msg_status : HMIS_ST_SUCCESS; // R8
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_r <= 1'b0;
      status_r <= HMIS_ST_SUCCESS;
    end else begin
      done_r <= ans_now;
      if (ans_now) status_r <= (take_req ? ans_code : HMIS_ST_SUCCESS);
    end
  end
  assign ans_done = done_r;
  assign ans_status = status_r;
endmodule

/* File: hmis_service_props.sv */
`timescale 1ns/1ps
// ========================================
// Port checker for the service block
module hmis_service_props
  import hmis_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [6:0] req_unit_index,
  input wire logic [6:0] req_mask_table,
  input wire logic ans_done,
  input wire logic [2:0] ans_status,
  input wire logic [6:0] ans_event_table,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_last,
  input wire logic xchg_start,
  input wire logic xchg_busy,
  input wire logic module_initialized,
  input wire logic [6:0] mask_table,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Taken requests; ok_take passed the unit index and initialization prechecks
  wire take = req_valid && req_ready;
  wire idx_ok = req_unit_index < UNIT_INDEX_LIMIT;
  wire ok_take = take && idx_ok && module_initialized;
  AST_BAD_INDEX: assert property (take && !idx_ok |=> ans_done && ans_status == 3'h1)
    else $error("out of range index not refused");
  AST_NOT_INIT: assert property (take && idx_ok && !module_initialized |=> ans_status == 3'h2)
    else $error("uninitialized module not refused");
  AST_MASK_WRITE: assert property (ok_take && req_op == 2'h2 |=> ans_done)
    else $error("mask write not answered");
  AST_MASK_HOLD: assert property (!(take && req_op == 2'h2) |=> $stable(mask_table))
    else $error("mask table changed without a write");
  AST_IRQ_MASKED: assert property (mask_table == 7'h7f |-> !irq)
    else $error("interrupt while all masked");
  AST_SUMMARY: assert property (ok_take && req_op == 2'h1 |=>
    ans_done && ans_event_table[0] == (|ans_event_table[6:1]))
    else $error("summary entry disagrees with events");
  AST_HIDE: assert property (ok_take && req_op == 2'h0 && xchg_busy |=>
    !ans_done || ans_status inside {3'h3, 3'h4, 3'h6, 3'h7})
    else $error("datagram delivered during exchange");
  AST_LAST_DONE: assert property (out_valid && out_ready && out_last |=>
    ans_done && ans_status == 3'h0 && req_ready)
    else $error("record end not answered");
  AST_XCHG_START: assert property (!xchg_busy && xchg_start |=> xchg_busy)
    else $error("exchange did not start");
  AST_STREAM_BLOCK: assert property (out_valid |-> !req_ready)
    else $error("request accepted while streaming");
  // Main scenarios reached
  CV_MASK: cover property (ok_take && req_op == 2'h2 && req_mask_table == 7'h00);
  CV_EVT: cover property (ans_done && ans_event_table[0]);
  CV_REC: cover property (out_valid && out_ready && out_last);
endmodule

/* File: hmis_rec_src.sv */
`timescale 1ns/1ps
// ========================================
// Far side record source feeding received records
module hmis_rec_src (
  input wire logic sys_clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [1:0] rx_kind,
  output logic [7:0] rx_byte,
  output logic rx_last
);
  initial begin
    rx_valid = 1'b0;
    rx_kind = 2'h0;
    rx_byte = 8'h00;
    rx_last = 1'b0;
  end
  // One record: source, codes, directed flag, length, data; held until taken
  task automatic send(input logic [1:0] kind, input logic [7:0] src, input logic [7:0] len);
    logic [7:0] b;
    for (int i = 0; i < 32'(len) + 5; i++) begin
      b = i == 0 ? src : i == 1 ? 8'h2a : i == 2 ? 8'h5c :
        i == 3 ? {7'h00, src != 8'hff} : i == 4 ? len : 8'ha0 + 8'(i);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_kind <= kind;
      rx_byte <= b;
      rx_last <= (i == 32'(len) + 4);
      @(negedge sys_clk);
      while (!rx_ready) @(negedge sys_clk);
    end
    // Released line shows the inverse so a stale byte is never mistaken
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_byte <= ~b;
  endtask
endmodule

/* File: hmis_service_tb_top.sv */
`timescale 1ns/1ps
// ========================================
// Bench for the host message and interrupt service
module hmis_service_tb_top;
  import hmis_pkg::*;
  logic sys_clk, rst, req_valid, req_ready, ans_done, out_valid, out_ready, out_last;
  logic rx_valid, rx_ready, rx_last, xchg_start, xchg_tx_fail, xchg_busy, irq, stall;
  logic module_initialized, module_failed, firmware_fault;
  logic [1:0] req_op, rx_kind;
  logic [6:0] req_unit_index, req_mask_table, ans_event_table, mask_table;
  logic [2:0] ans_status;
  logic [7:0] out_byte, rx_byte;
  logic [3:0] ev;
  logic last_seen;
  logic [7:0] q[$];
  int fails = 0;
  int n_checks = 0;
  // Short reply timeout keeps the run brief
  hmis_service #(.REPLY_TIMEOUT(32'd50)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_unit_index(req_unit_index), .req_mask_table(req_mask_table), .ans_done(ans_done),
    .ans_status(ans_status), .ans_event_table(ans_event_table), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .out_last(out_last), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_kind(rx_kind), .rx_byte(rx_byte), .rx_last(rx_last),
    .xchg_start(xchg_start), .xchg_tx_fail(xchg_tx_fail),
    .module_initialized(module_initialized), .module_failed(module_failed),
    .firmware_fault(firmware_fault), .ev_module_status(ev[0]), .ev_device_status(ev[1]),
    .ev_outputs_sent(ev[2]), .ev_command_done(ev[3]), .xchg_busy(xchg_busy),
    .mask_table(mask_table), .irq(irq));
  hmis_rec_src u_src (.sys_clk(sys_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_byte(rx_byte), .rx_last(rx_last));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Host drops out_ready every other cycle when asked
  always @(posedge sys_clk) out_ready <= stall ? ~out_ready : 1'b1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One host request; record bytes collected into q until the answer
  task automatic req(input logic [1:0] op, input logic [6:0] idx, input logic [6:0] m);
    int n;
    q = {};
    n = 0;
    last_seen = 1'b0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_unit_index <= idx;
    req_mask_table <= m;
    @(negedge sys_clk);
    while (!req_ready) @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      if (out_valid && out_ready) begin
        q.push_back(out_byte);
        last_seen = out_last;
      end
      n++;
    end while (ans_done !== 1'b1 && n < 2000);
    // A request left unanswered counts as a mismatch
    chk({7'h00, ans_done}, 8'h01);
  endtask
  task automatic st(input logic [1:0] op, input logic [6:0] idx, input logic [2:0] exp);
    req(op, idx, 7'h7f);
    chk({5'h00, ans_status}, {5'h00, exp});
  endtask
  task automatic rd(input logic [7:0] src, input logic [7:0] len);
    st(2'h0, 7'h01, 3'h0);
    chk(8'(q.size()), len + 8'h05);
    chk({7'h00, last_seen}, 8'h01);
    foreach (q[i]) chk(q[i], i == 0 ? src : i == 1 ? 8'h2a : i == 2 ? 8'h5c :
      i == 3 ? {7'h00, src != 8'hff} : i == 4 ? len : 8'ha0 + 8'(i));
  endtask
  initial begin
    {rst, stall, out_ready, module_initialized} = 4'hf;
    {req_valid, req_op, req_unit_index, req_mask_table, ev} = '0;
    {xchg_start, xchg_tx_fail, module_failed, firmware_fault} = 4'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({1'b0, mask_table}, 8'h7f);
    st(2'h0, 7'h01, 3'h5);
    st(2'h3, 7'h01, 3'h0);
    st(2'h1, 7'h40, 3'h1);
    @(posedge sys_clk) module_initialized <= 1'b0;
    st(2'h1, 7'h00, 3'h2);
    @(posedge sys_clk) {module_initialized, module_failed} <= 2'b11;
    st(2'h1, 7'h3f, 3'h3);
    @(posedge sys_clk) {module_failed, firmware_fault} <= 2'b01;
    st(2'h0, 7'h01, 3'h7);
    @(posedge sys_clk) firmware_fault <= 1'b0;
    // Non-memory record arrives first; memory record still wins
    u_src.send(2'h1, 8'hff, 8'h00);
    u_src.send(2'h0, 8'h05, 8'h02);
    st(2'h1, 7'h01, 3'h0);
    chk({1'b0, ans_event_table}, 8'h43);
    chk({7'h00, irq}, 8'h00);
    st(2'h1, 7'h01, 3'h0);
    chk({1'b0, ans_event_table}, 8'h00);
    stall = 1'b1;
    rd(8'h05, 8'h02);
    stall = 1'b0;
    rd(8'hff, 8'h00);
    st(2'h0, 7'h01, 3'h5);
    req(2'h2, 7'h01, 7'h00);
    chk({1'b0, mask_table}, 8'h00);
    @(posedge sys_clk) ev <= 4'hf;
    @(posedge sys_clk) ev <= 4'h0;
    @(negedge sys_clk) chk({7'h00, irq}, 8'h01);
    st(2'h1, 7'h01, 3'h0);
    chk({1'b0, ans_event_table}, 8'h3d);
    chk({7'h00, irq}, 8'h00);
    req(2'h2, 7'h01, 7'h55);
    chk({1'b0, mask_table}, 8'h55);
    // Exchange hides a waiting datagram until its reply is taken
    u_src.send(2'h0, 8'h03, 8'h01);
    @(posedge sys_clk) xchg_start <= 1'b1;
    @(posedge sys_clk) xchg_start <= 1'b0;
    @(negedge sys_clk) chk({7'h00, xchg_busy}, 8'h01);
    st(2'h0, 7'h01, 3'h4);
    u_src.send(2'h2, 8'h09, 8'h03);
    rd(8'h09, 8'h03);
    chk({7'h00, xchg_busy}, 8'h00);
    rd(8'h03, 8'h01);
    @(posedge sys_clk) xchg_start <= 1'b1;
    @(posedge sys_clk) xchg_start <= 1'b0;
    repeat (60) @(posedge sys_clk);
    st(2'h0, 7'h01, 3'h6);
    @(posedge sys_clk) xchg_start <= 1'b1;
    @(posedge sys_clk) {xchg_start, xchg_tx_fail} <= 2'b01;
    @(posedge sys_clk) xchg_tx_fail <= 1'b0;
    st(2'h0, 7'h01, 3'h6);
    // Source address out of range: record must be dropped, not delivered
    u_src.send(2'h0, 8'h20, 8'h00);
    st(2'h0, 7'h01, 3'h5);
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
bind hmis_service hmis_service_props u_props (.sys_clk(sys_clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
  .req_unit_index(req_unit_index), .req_mask_table(req_mask_table), .ans_done(ans_done),
  .ans_status(ans_status), .ans_event_table(ans_event_table), .out_valid(out_valid),
  .out_ready(out_ready), .out_last(out_last), .xchg_start(xchg_start),
  .xchg_busy(xchg_busy), .module_initialized(module_initialized),
  .mask_table(mask_table), .irq(irq));
